// ==== hdl/rxlof_pkg.sv ====
`default_nettype none

package rxlof_pkg;

    // Per-channel pin sampling vector layout
    localparam int CH_SYNC_W      = 4;
    localparam int CH_CLK_BIT     = 0;
    localparam int CH_LINE_A_BIT  = 1;
    localparam int CH_LINE_B_BIT  = 2;
    localparam int CH_TXNEG_BIT   = 3;

    // Shared mode pin sampling vector layout
    localparam int GL_SYNC_W      = 3;
    localparam int GL_INV_BIT     = 0;
    localparam int GL_RAIL_BIT    = 1;
    localparam int GL_HOST_BIT    = 2;

    // Decoder geometry
    localparam int PIPE_DEPTH     = 4;
    localparam int B3ZS_WIN       = 3;
    localparam int HDB3_WIN       = 4;
    localparam int ZRUN_W         = 3;

    // Defaults of the top-level parameters
    localparam int NUM_CH_DEF     = 4;
    localparam int FIFO_DEPTH_DEF = 2;

    // Values after reset
    localparam logic                 RST_BIT    = 1'h0;
    localparam logic                 RST_CS_N   = 1'h1;
    localparam logic [ZRUN_W-1:0]    RST_ZRUN   = 3'h0;
    localparam logic [GL_SYNC_W-1:0] RST_GL_PINS = 3'h3; // Invert and rail pins idle high

    // One received symbol as it moves through decoder and buffer
    typedef struct packed {
        logic mark;   // Pulse present in this bit slot
        logic neg;    // Pulse was of negative polarity
        logic lcv;    // Line code violation tied to this slot
    } rxlof_sym_t;

    localparam rxlof_sym_t SYM_IDLE = 3'h0;

    // Effective per-channel configuration
    typedef struct packed {
        logic single;  // Single-rail output with violation flag
        logic dec_en;  // Zero-substitution decoder active
        logic hdb3;    // Four-bit substitution code instead of three-bit
    } rxlof_cfg_t;

endpackage

`default_nettype wire

// ==== hdl/rxlof_formatter.sv ====
`default_nettype none

module rxlof_formatter #(
    parameter int NUM_CH     = rxlof_pkg::NUM_CH_DEF,     // Number of channels
    parameter int FIFO_DEPTH = rxlof_pkg::FIFO_DEPTH_DEF  // Entries of the output buffer
) (
    input  wire logic              clk,                 // System clock, 250 MHz
    input  wire logic              rst_n,               // Synchronous reset, active low
    input  wire logic              ce,                  // Clock enable, freezes state when low
    input  wire logic [NUM_CH-1:0] rec_clk_in,          // Recovered clock from clock recovery
    input  wire logic [NUM_CH-1:0] line_in_a,           // Sliced positive line pulse
    input  wire logic [NUM_CH-1:0] line_in_b,           // Sliced negative line pulse
    input  wire logic [NUM_CH-1:0] tx_neg_data_in,      // Transmit negative data pin
    input  wire logic [NUM_CH-1:0] hdb3_sel,            // High: four-bit substitution code
    input  wire logic [NUM_CH-1:0] rx_hold,             // Terminal stall of output updates
    input  wire logic [NUM_CH-1:0] rx_eq_enable,        // Equalizer enable pins
    input  wire logic              rx_clk_invert_sel,   // Clock invert select pin
    input  wire logic              rail_mode_select,    // Rail select or chip select pin
    input  wire logic              select_a,            // High: host mode, low: hardware mode
    input  wire logic              cmd_clk_invert,      // Command register clock invert bit
    input  wire logic [NUM_CH-1:0] chan_rail_mode_bit,  // Command register rail bits
    input  wire logic [NUM_CH-1:0] cmd_eq_enable,       // Command register equalizer bits
    output logic      [NUM_CH-1:0] recovered_clk_out,   // Receive clock outputs
    output logic      [NUM_CH-1:0] rx_pos_data_out,     // Positive or single-rail data
    output logic      [NUM_CH-1:0] rx_neg_data_out,     // Negative data or violation
    output logic      [NUM_CH-1:0] line_violation_flag, // Violation flag, single-rail only
    output logic      [NUM_CH-1:0] eq_enable_out,       // Equalizer control
    output logic      [NUM_CH-1:0] fifo_in_ready,       // Buffer accepts a symbol
    output logic                   serial_cs_n          // Serial interface chip select, active low
);

    // Parameters the buffer logic cannot serve are refused at elaboration
    if (NUM_CH < 1 || FIFO_DEPTH < 2 || FIFO_DEPTH > 7) begin : g_bad_param
        $error("rxlof_formatter: unsupported NUM_CH or FIFO_DEPTH");
    end

    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam int PTR_W = (FIFO_DEPTH > 2) ? $clog2(FIFO_DEPTH) : 1;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Shared mode pins, three-stage sampling

    logic [rxlof_pkg::GL_SYNC_W-1:0] gl_s1_r;
    logic [rxlof_pkg::GL_SYNC_W-1:0] gl_s2_r;
    logic [rxlof_pkg::GL_SYNC_W-1:0] gl_s3_r;
    logic [rxlof_pkg::GL_SYNC_W-1:0] gl_filt_r;
    logic                            host_mode;
    logic                            invert_eff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Samplers start at the pulled-up levels of the invert and rail pins
            gl_s1_r   <= rxlof_pkg::RST_GL_PINS;
            gl_s2_r   <= rxlof_pkg::RST_GL_PINS;
            gl_s3_r   <= rxlof_pkg::RST_GL_PINS;
            gl_filt_r <= rxlof_pkg::RST_GL_PINS;
        end else if (ce) begin
            gl_s1_r <= {select_a, rail_mode_select, rx_clk_invert_sel};
            gl_s2_r <= gl_s1_r;
            gl_s3_r <= gl_s2_r;
            for (int k = 0; k < rxlof_pkg::GL_SYNC_W; k++) begin
                if (gl_s2_r[k] == gl_s3_r[k]) begin
                    gl_filt_r[k] <= gl_s3_r[k];
                end
            end
        end
    end

    assign host_mode  = gl_filt_r[rxlof_pkg::GL_HOST_BIT];
    // In hardware mode an open invert pin reads high, so falling-edge updates are selected
    assign invert_eff = host_mode ? cmd_clk_invert : gl_filt_r[rxlof_pkg::GL_INV_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_cs_n <= rxlof_pkg::RST_CS_N;
        end else if (ce) begin
            serial_cs_n <= host_mode ? gl_filt_r[rxlof_pkg::GL_RAIL_BIT] : rxlof_pkg::RST_CS_N;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel datapath

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch

        logic [rxlof_pkg::CH_SYNC_W-1:0] s1_r;
        logic [rxlof_pkg::CH_SYNC_W-1:0] s2_r;
        logic [rxlof_pkg::CH_SYNC_W-1:0] s3_r;
        logic [rxlof_pkg::CH_SYNC_W-1:0] filt_r;
        logic                            clk_prev_r;
        logic                            rise_evt;
        logic                            fall_evt;
        rxlof_pkg::rxlof_cfg_t           cfg;
        rxlof_pkg::rxlof_sym_t           cap_r;
        rxlof_pkg::rxlof_sym_t           pipe_r   [rxlof_pkg::PIPE_DEPTH];
        rxlof_pkg::rxlof_sym_t           pipe_nxt [rxlof_pkg::PIPE_DEPTH];
        logic                            last_neg_r;
        logic                            seen_r;
        logic [rxlof_pkg::ZRUN_W-1:0]    zrun_r;
        logic [rxlof_pkg::ZRUN_W-1:0]    zrun_nxt;
        logic [rxlof_pkg::ZRUN_W-1:0]    win;
        logic                            is_v;
        logic                            sub_ok;
        logic                            shift;
        rxlof_pkg::rxlof_sym_t           mem_r    [FIFO_DEPTH];
        logic [PTR_W-1:0]                wptr_r;
        logic [PTR_W-1:0]                rptr_r;
        logic [CNT_W-1:0]                cnt_r;
        logic                            out_valid;
        logic                            pop;
        rxlof_pkg::rxlof_sym_t           head;

        // Line pins and recovered clock, three stages, change once stages agree
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                s1_r       <= '0;
                s2_r       <= '0;
                s3_r       <= '0;
                filt_r     <= '0;
                clk_prev_r <= rxlof_pkg::RST_BIT;
            end else if (ce) begin
                s1_r <= {tx_neg_data_in[ch], line_in_b[ch], line_in_a[ch], rec_clk_in[ch]};
                s2_r <= s1_r;
                s3_r <= s2_r;
                for (int k = 0; k < rxlof_pkg::CH_SYNC_W; k++) begin
                    if (s2_r[k] == s3_r[k]) begin
                        filt_r[k] <= s3_r[k];
                    end
                end
                clk_prev_r <= filt_r[rxlof_pkg::CH_CLK_BIT];
            end
        end

        assign rise_evt = filt_r[rxlof_pkg::CH_CLK_BIT] & ~clk_prev_r;
        assign fall_evt = ~filt_r[rxlof_pkg::CH_CLK_BIT] & clk_prev_r;

        always_comb begin
            cfg.single = host_mode ? chan_rail_mode_bit[ch] : gl_filt_r[rxlof_pkg::GL_RAIL_BIT];
            cfg.dec_en = cfg.single & ~filt_r[rxlof_pkg::CH_TXNEG_BIT];
            cfg.hdb3   = hdb3_sel[ch];
        end

        // Equalizer follows its pin in hardware mode, the command bit in host mode
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                eq_enable_out[ch] <= rxlof_pkg::RST_BIT;
            end else if (ce) begin
                eq_enable_out[ch] <= host_mode ? cmd_eq_enable[ch] : rx_eq_enable[ch];
            end
        end

        // Line sampled mid-bit, on the falling edge of the recovered clock
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                cap_r <= rxlof_pkg::SYM_IDLE;
            end else if (ce && fall_evt) begin
                cap_r.mark <= filt_r[rxlof_pkg::CH_LINE_A_BIT] ^ filt_r[rxlof_pkg::CH_LINE_B_BIT];
                cap_r.neg  <= filt_r[rxlof_pkg::CH_LINE_B_BIT];
                cap_r.lcv  <= rxlof_pkg::RST_BIT;
            end
        end

        // Decoder: a pulse repeating the last polarity is a violation pulse
        always_comb begin
            win    = cfg.hdb3 ? rxlof_pkg::ZRUN_W'(rxlof_pkg::HDB3_WIN)
                              : rxlof_pkg::ZRUN_W'(rxlof_pkg::B3ZS_WIN);
            is_v   = cfg.dec_en & cap_r.mark & seen_r & (cap_r.neg == last_neg_r);
            sub_ok = ~pipe_r[0].mark & (~cfg.hdb3 | ~pipe_r[1].mark);
            pipe_nxt[0] = cap_r;
            for (int k = 1; k < rxlof_pkg::PIPE_DEPTH; k++) begin
                pipe_nxt[k] = pipe_r[k-1];
            end
            if (is_v && sub_ok) begin
                for (int k = 0; k < rxlof_pkg::PIPE_DEPTH; k++) begin
                    if (k < int'(win)) begin
                        pipe_nxt[k].mark = 1'b0;
                    end
                end
            end
            if (is_v && !sub_ok) begin
                pipe_nxt[0].lcv = 1'b1;
            end
            if (cfg.dec_en && !cap_r.mark && zrun_r == win - 1'b1) begin
                pipe_nxt[0].lcv = 1'b1;
            end
            if (cap_r.mark) begin
                zrun_nxt = rxlof_pkg::RST_ZRUN;
            end else if (zrun_r == win) begin
                zrun_nxt = zrun_r;
            end else begin
                zrun_nxt = zrun_r + 1'b1;
            end
        end

        // Decoder advances once per bit, stalled while the buffer is full
        assign fifo_in_ready[ch] = (cnt_r != CNT_W'(FIFO_DEPTH));
        assign shift             = rise_evt & fifo_in_ready[ch];

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                for (int k = 0; k < rxlof_pkg::PIPE_DEPTH; k++) begin
                    pipe_r[k] <= rxlof_pkg::SYM_IDLE;
                end
                last_neg_r <= rxlof_pkg::RST_BIT;
                seen_r     <= rxlof_pkg::RST_BIT;
                zrun_r     <= rxlof_pkg::RST_ZRUN;
            end else if (ce && shift) begin
                for (int k = 0; k < rxlof_pkg::PIPE_DEPTH; k++) begin
                    pipe_r[k] <= pipe_nxt[k];
                end
                zrun_r <= zrun_nxt;
                if (cap_r.mark) begin
                    last_neg_r <= cap_r.neg;
                    seen_r     <= 1'b1;
                end
            end
        end

        // FIFO_DEPTH-entry buffer between decoder and output pins
        assign out_valid = (cnt_r != '0);
        assign pop       = rise_evt & ~rx_hold[ch] & out_valid;
        assign head      = mem_r[rptr_r];

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                for (int k = 0; k < FIFO_DEPTH; k++) begin
                    mem_r[k] <= rxlof_pkg::SYM_IDLE;
                end
                wptr_r <= '0;
                rptr_r <= '0;
                cnt_r  <= '0;
            end else if (ce) begin
                if (shift) begin
                    mem_r[wptr_r] <= pipe_r[rxlof_pkg::PIPE_DEPTH-1];
                    wptr_r        <= ptr_inc(wptr_r);
                end
                if (pop) begin
                    rptr_r <= ptr_inc(rptr_r);
                end
                if (shift && !pop) begin
                    cnt_r <= cnt_r + 1'b1;
                end else if (pop && !shift) begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end

        // Outputs change on the internal rising edge; inverting the clock output
        // moves that change onto its falling edge
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                recovered_clk_out[ch] <= rxlof_pkg::RST_BIT;
            end else if (ce) begin
                recovered_clk_out[ch] <= filt_r[rxlof_pkg::CH_CLK_BIT] ^ invert_eff;
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                rx_pos_data_out[ch]     <= rxlof_pkg::RST_BIT;
                rx_neg_data_out[ch]     <= rxlof_pkg::RST_BIT;
                line_violation_flag[ch] <= rxlof_pkg::RST_BIT;
            end else if (ce && pop) begin
                if (cfg.single) begin
                    rx_pos_data_out[ch]     <= head.mark;
                    rx_neg_data_out[ch]     <= head.lcv;
                    line_violation_flag[ch] <= head.lcv;
                end else begin
                    rx_pos_data_out[ch]     <= head.mark & ~head.neg;
                    rx_neg_data_out[ch]     <= head.mark & head.neg;
                    line_violation_flag[ch] <= 1'b0;
                end
            end
        end

    end

endmodule

`default_nettype wire

// ==== verification/rxlof_chk.sv ====
`default_nettype none

module rxlof_chk #(
    parameter int NUM_CH     = 4, // Channel count
    parameter int FIFO_DEPTH = 2  // Buffer entries
) (
    input wire logic              clk,                 // System clock
    input wire logic              rst_n,               // Reset, active low
    input wire logic [NUM_CH-1:0] rec_clk_in,          // Recovered clock in
    input wire logic [NUM_CH-1:0] rx_eq_enable,        // Equalizer pins
    input wire logic              rx_clk_invert_sel,   // Invert pin
    input wire logic              rail_mode_select,    // Rail or chip select pin
    input wire logic              select_a,            // Host mode
    input wire logic              cmd_clk_invert,      // Command invert bit
    input wire logic [NUM_CH-1:0] chan_rail_mode_bit,  // Command rail bits
    input wire logic [NUM_CH-1:0] cmd_eq_enable,       // Command equalizer bits
    input wire logic [NUM_CH-1:0] recovered_clk_out,   // Receive clock out
    input wire logic [NUM_CH-1:0] rx_pos_data_out,     // Positive data
    input wire logic [NUM_CH-1:0] rx_neg_data_out,     // Negative data or violation
    input wire logic [NUM_CH-1:0] line_violation_flag, // Violation flag
    input wire logic [NUM_CH-1:0] eq_enable_out,       // Equalizer control
    input wire logic [NUM_CH-1:0] fifo_in_ready,       // Buffer not full
    input wire logic              serial_cs_n,         // Chip select out
    input wire logic              ce                   // Clock enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]        since_rst_r;
    logic [NUM_CH-1:0] eq_exp;
    logic       inv_eff;
    logic       single_eff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    always_ff @(posedge clk) begin
        if (!rst_n) since_rst_r <= 4'h0;
        else if (since_rst_r != 4'hF) since_rst_r <= since_rst_r + 4'h1;
    end
    assign inv_eff    = select_a ? cmd_clk_invert : rx_clk_invert_sel;
    assign single_eff = select_a ? chan_rail_mode_bit[0] : rail_mode_select;
    assign eq_exp     = select_a ? cmd_eq_enable : rx_eq_enable;

    ////////////////////////////////////////////////////////////////////////////////
    property p_clk_follow;
        $rose(rec_clk_in[0]) |-> ##[2:7] (recovered_clk_out[0] != inv_eff);
    endproperty
    a_clk_follow: assert property (p_clk_follow) else $error("receive clock does not follow");
    property p_upd_edge;
        $changed(rx_pos_data_out[0]) || $changed(rx_neg_data_out[0]) |-> ##[0:2] (recovered_clk_out[0] != inv_eff);
    endproperty
    a_upd_edge: assert property (p_upd_edge) else $error("data changed on wrong clock edge");
    property p_dual_excl;
        !single_eff |-> !(rx_pos_data_out[0] && rx_neg_data_out[0]);
    endproperty
    a_dual_excl: assert property (p_dual_excl) else $error("both rails high in dual-rail");
    property p_dual_noflag;
        !single_eff |-> !$rose(line_violation_flag[0]);
    endproperty
    a_dual_noflag: assert property (p_dual_noflag) else $error("violation flag in dual-rail");
    property p_flag_copy;
        single_eff |-> line_violation_flag[0] == rx_neg_data_out[0];
    endproperty
    a_flag_copy: assert property (p_flag_copy) else $error("violation not on negative output");
    property p_flag_hold;
        $rose(line_violation_flag[0]) |-> line_violation_flag[0] [*6];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("violation flag too short");
    property p_eq;
        since_rst_r > 4'h8 && $past(select_a, 7) == select_a
            |=> eq_enable_out == $past(eq_exp);
    endproperty
    a_eq: assert property (p_eq) else $error("equalizer control wrong");
    property p_cs;
        since_rst_r > 4'h8 && $past(select_a, 7) == select_a && $past(rail_mode_select, 7) == rail_mode_select
            |-> serial_cs_n == (select_a ? rail_mode_select : 1'h1);
    endproperty
    a_cs: assert property (p_cs) else $error("chip select wrong");
    property p_rst_out;
        !$past(rst_n) |-> fifo_in_ready == {NUM_CH{1'h1}} && rx_pos_data_out == '0 && serial_cs_n;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");

    c_flag: cover property ($rose(line_violation_flag[0]));
    c_full: cover property ($fell(fifo_in_ready[0]));
    c_host: cover property (select_a && $changed(rx_pos_data_out[0]));
endmodule

`default_nettype wire

// ==== verification/rxlof_framer_model.sv ====
`default_nettype none

module rxlof_framer_model #(
    parameter int NUM_CH = 2 // Channel count
) (
    input  wire logic              clk,               // System clock
    input  wire logic              inv,               // Receive clock is inverted
    input  wire logic              stall,             // Slow framer
    input  wire logic              dec_off,           // Request decoder bypass
    input  wire logic [NUM_CH-1:0] recovered_clk_out, // Receive clocks
    input  wire logic [NUM_CH-1:0] rx_pos_data_out,   // Positive data
    input  wire logic [NUM_CH-1:0] rx_neg_data_out,   // Negative data or violation
    output logic      [NUM_CH-1:0] rx_hold,           // Stall of output updates
    output logic      [NUM_CH-1:0] tx_neg_data_in     // Transmit negative data pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q;
    logic cap_pos[$];
    logic cap_neg[$];

    assign rx_hold        = {NUM_CH{stall}};
    assign tx_neg_data_in = {NUM_CH{dec_off}};
    // Sample mid-bit, on the receive clock edge opposite to the update edge
    always @(posedge clk) begin
        clk_q <= recovered_clk_out[0];
        if (clk_q != recovered_clk_out[0] && recovered_clk_out[0] == inv && !stall) begin
            cap_pos.push_back(rx_pos_data_out[0]);
            cap_neg.push_back(rx_neg_data_out[0]);
        end
    end
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 2;
    logic           clk = 1'h0, rst_n = 1'h0, ce = 1'h1, rail = 1'h0, sel = 1'h0, inv_pin = 1'h0;
    logic           cmd_inv = 1'h0, finv = 1'h0, stall = 1'h0, dec_off = 1'h0, cs_n;
    logic [NCH-1:0] rclk = '0, la = '1, lb = '1, hdb = '0, eqp = 2'h1, crail = '0, ceq = 2'h2;
    logic [NCH-1:0] txn, hold, clk_out, pos, neg, flag, eqo, rdy;
    int             failures = 0, compares = 0;

    rxlof_formatter #(.NUM_CH(NCH), .FIFO_DEPTH(2)) DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .rec_clk_in(rclk), .line_in_a(la), .line_in_b(lb),
        .tx_neg_data_in(txn), .hdb3_sel(hdb), .rx_hold(hold), .rx_eq_enable(eqp),
        .rx_clk_invert_sel(inv_pin), .rail_mode_select(rail), .select_a(sel), .cmd_clk_invert(cmd_inv),
        .chan_rail_mode_bit(crail), .cmd_eq_enable(ceq), .recovered_clk_out(clk_out),
        .rx_pos_data_out(pos), .rx_neg_data_out(neg), .line_violation_flag(flag),
        .eq_enable_out(eqo), .fifo_in_ready(rdy), .serial_cs_n(cs_n));
    rxlof_framer_model #(.NUM_CH(NCH)) u_framer (.clk(clk), .inv(finv), .stall(stall), .dec_off(dec_off),
        .recovered_clk_out(clk_out), .rx_pos_data_out(pos), .rx_neg_data_out(neg),
        .rx_hold(hold), .tx_neg_data_in(txn));

    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        rst_n = 1'h0;
        repeat (10) @(negedge clk);
        rst_n = 1'h1;
        repeat (10) @(negedge clk);
    endtask

    // One line symbol per receive clock period; the clock stands low between frames
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            rclk = '1;
            la = {NCH{s[i] == "+"}};
            lb = {NCH{s[i] == "-"}};
            repeat (4) @(negedge clk);
            rclk = '0;
            repeat (4) @(negedge clk);
        end
        la = '1;
        lb = '1;
        @(negedge clk);
    endtask

    task automatic run(input string name, input string line, input string ep, input string en);
        int k;
        do_reset();
        u_framer.cap_pos.delete();
        u_framer.cap_neg.delete();
        send({line, "+-+-+-+-"});
        repeat (8) @(negedge clk);
        k = 0;
        while (k < u_framer.cap_pos.size() && !(u_framer.cap_pos[k] | u_framer.cap_neg[k])) k++;
        for (int i = 0; i < ep.len(); i++) begin
            check("pos", 4'(u_framer.cap_pos[k + i]), 4'(ep[i] == "1"));
            check("neg", 4'(u_framer.cap_neg[k + i]), 4'(en[i] == "1"));
        end
        $display("test %s done", name);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        @(negedge clk);
        run("dual_hw", "+-0+0--+", "10010001", "01000110");
        check("eq_hw", 4'(eqo), 4'h1);
        check("cs_hw", 4'(cs_n), 4'h1);
        sel = 1'h1;
        cmd_inv = 1'h1;
        finv = 1'h1;
        run("dual_host_inv", "+-0+0--+", "10010001", "01000110");
        check("eq_host", 4'(eqo), 4'h2);
        check("cs_host", 4'(cs_n), 4'h0);
        sel = 1'h0;
        rail = 1'h1;
        inv_pin = 1'h1;
        run("b3zs_hw", "+00+-+-0-++-", "100011000111", "000000000010");
        sel = 1'h1;
        cmd_inv = 1'h0;
        finv = 1'h0;
        crail = '1;
        hdb = '1;
        run("hdb3_host", "+000+-+-00-+-", "1000011000011", "0000000000000");
        sel = 1'h0;
        finv = 1'h1;
        hdb = '0;
        dec_off = 1'h1;
        run("b3zs_bypass", "+00+-+-0-++-", "100111101111", "000000000000");
        dec_off = 1'h0;
        rail = 1'h0;
        inv_pin = 1'h0;
        finv = 1'h0;
        do_reset();
        stall = 1'h1;
        send("+-+-+-+-+-+-");
        check("full", 4'(rdy[0]), 4'h0);
        stall = 1'h0;
        ce = 1'h0;
        send("+");
        check("frozen", 4'(rdy[0]), 4'h0);
        ce = 1'h1;
        send("+");
        check("drain", 4'(rdy[0]), 4'h1);
        $display("test stall done");
        summarize();
    end

    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule

bind rxlof_formatter rxlof_chk #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk(clk), .rst_n(rst_n), .rec_clk_in(rec_clk_in), .rx_eq_enable(rx_eq_enable),
    .rx_clk_invert_sel(rx_clk_invert_sel), .rail_mode_select(rail_mode_select), .select_a(select_a),
    .cmd_clk_invert(cmd_clk_invert), .chan_rail_mode_bit(chan_rail_mode_bit), .cmd_eq_enable(cmd_eq_enable),
    .recovered_clk_out(recovered_clk_out), .rx_pos_data_out(rx_pos_data_out),
    .rx_neg_data_out(rx_neg_data_out), .line_violation_flag(line_violation_flag),
    .eq_enable_out(eq_enable_out), .fifo_in_ready(fifo_in_ready), .serial_cs_n(serial_cs_n), .ce(ce));

`default_nettype wire
